// ==== rtl/lin_bus_node_controller.sv ====
// LIN commander/responder node with classic Wishbone register slave
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`include "lin_node_regs.svh"
module lin_bus_node_controller #(
   parameter logic [31:0] WAKE_WAIT_CYC = `WAKE_WAIT_CYC,
   parameter logic [31:0] WAKE_SERIES_CYC = `WAKE_SERIES_CYC,
   parameter logic [31:0] BUS_IDLE_CYC = `BUS_IDLE_CYC
)(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic wb_we_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic debug_halt_in,
   input wire logic bus_receive_in,
   output logic bus_transmit_out,
   output logic irq_out
);
   logic [31:0] ctrl, inten;
   logic [23:0] presc;
   logic [3:0] frac;
   logic [7:0] idb, task_b, mask, rid;
   logic [7:0] txb [8];
   logic [7:0] rxb [8];
   logic [`NFLAG-1:0] flags, ev, ev_f;
   logic ev_sy, ev_nr, ev_bt, ev_w1, ev_w3;
   lin_node_pkg::frame_t st;
   lin_node_pkg::wake_t wk;
   lin_node_pkg::parity_t pmode;

   wire loopb = ctrl[`C_LOOP];
   wire cmdr = ctrl[`C_CMDR];
   wire big = ctrl[`C_BIG];
   wire adapt_en = ctrl[`C_ADAPT] & ~cmdr;
   assign pmode = lin_node_pkg::parity_t'(ctrl[`C_PAR_LO+:2]);

   // Wishbone slave, one wait state; write lands on the ack edge
   wire wb_req = wb_cyc_in & wb_stb_in;
   wire [7:0] adr = {wb_adr_in[7:2], 2'b00};
   wire wr = wb_req & wb_we_in & wb_ack_out;
   wire [31:0] bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                        {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   wire [31:0] wdat = wb_dat_in & bmask;

   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~bmask) | wdat;
   endfunction

   wire start_hdr = wr & adr == `OFF_ID & wb_sel_in[0] & cmdr; // R12
   wire wake_go = wr & adr == `OFF_CTRL & wdat[`C_WAKE] & ~cmdr;

   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
         wb_ack_out <= 1'b0;
      else
         wb_ack_out <= wb_req & ~wb_ack_out;

   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         ctrl <= `CTRL_RST;
         presc <= `PRESC_RST;
         frac <= `FRAC_RST;
         {mask, task_b, idb} <= 24'(`ID_RST);
         inten <= 32'h00000000;
      end
      else if (wr)
      begin
         case (adr)
            `OFF_CTRL: ctrl <= merge(ctrl) & 32'h00007FFF;
            `OFF_PRESC: presc <= 24'(merge({8'h00, presc})); // R06
            `OFF_FRAC: frac <= 4'(merge({28'h0000000, frac})); // R06
            `OFF_ID: {mask, task_b, idb} <= 24'(merge({8'h00, mask,
               task_b, idb}));
            `OFF_INTEN: inten <= merge(inten) & 32'h000007FF;
            default: ;
         endcase
      end

   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         for (int i = 0; i < 8; i++)
            txb[i] <= 8'h00;
      end
      else if (wr & (adr == `OFF_DATA_LO | adr == `OFF_DATA_HI))
      begin
         for (int i = 0; i < 4; i++)
            if (wb_sel_in[i])
               txb[{adr[2], 2'(i)}] <= wb_dat_in[8*i+:8];
      end

   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
         wb_dat_out <= 32'h00000000;
      else if (wb_req & ~wb_ack_out)
      begin
         case (adr)
            `OFF_CTRL: wb_dat_out <= ctrl;
            `OFF_PRESC: wb_dat_out <= {8'h00, presc};
            `OFF_FRAC: wb_dat_out <= {28'h0000000, frac};
            `OFF_ID: wb_dat_out <= {8'h00, mask, task_b, idb};
            `OFF_INTEN: wb_dat_out <= inten;
            `OFF_STAT: wb_dat_out <= {7'h00, st != lin_node_pkg::ST_IDLE,
               rid, 5'h00, flags};
            `OFF_DATA_LO: wb_dat_out <= {rxb[3], rxb[2], rxb[1], rxb[0]};
            `OFF_DATA_HI: wb_dat_out <= {rxb[7], rxb[6], rxb[5], rxb[4]};
            default: wb_dat_out <= 32'h00000000;
         endcase
      end

   // Sticky flags, write one to clear; a new event beats the clear
   wire [`NFLAG-1:0] clr = (wr & adr == `OFF_STAT) ?
      wdat[`NFLAG-1:0] : '0;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
         flags <= '0;
      else
         flags <= (flags & ~clr) | ev;

   assign irq_out = |(flags & inten[`NFLAG-1:0]);

   // Bit time in system clocks; module clock is half the system clock
   logic [29:0] adapt_len;
   logic adapt_ok;
   wire [29:0] fix_len = 30'((30'(presc) + 30'h1) * 30'h20
      + 30'(frac) * 30'h2); // R07
   wire [29:0] bit_len = (adapt_en & adapt_ok) ? adapt_len : fix_len; // R16

   // Pin filter: a level counts once the last two stages agree
   logic s1, s2, s3, rxf;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         {s1, s2, s3, rxf} <= 4'hF;
      end
      else
      begin
         s1 <= bus_receive_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            rxf <= s3;
      end

   logic tx_bit, brk_drive, wk_drive, tx_busy, rb;
   wire tx_line = tx_bit & ~brk_drive & ~wk_drive;
   wire line = loopb ? tx_line : rxf; // R01
   logic line_d;
   wire fall = line_d & ~line;

   // Free-run lets a frame in flight finish before it freezes
   wire run = ~(debug_halt_in & (~ctrl[`C_FREE] |
      (st == lin_node_pkg::ST_IDLE & ~tx_busy & ~rb))); // R02

   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         line_d <= 1'b1;
         bus_transmit_out <= 1'b1;
      end
      else
      begin
         line_d <= line;
         bus_transmit_out <= loopb | tx_line; // R01
      end

   // Byte transmitter, LSB first with start and stop
   logic tx_go;
   logic [7:0] tx_d;
   logic [9:0] tsh;
   logic [3:0] tn;
   logic [29:0] tc;
   assign tx_busy = tn != 4'h0;
   assign tx_bit = tx_busy ? tsh[0] : 1'b1;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         tsh <= 10'h3FF;
         tn <= 4'h0;
         tc <= 30'h0;
      end
      else if (run)
      begin
         if (tx_go)
         begin
            tsh <= {1'b1, tx_d, 1'b0};
            tn <= 4'hA;
            tc <= 30'h0;
         end
         else if (tx_busy)
         begin
            if (tc == bit_len - 30'h1)
            begin
               tc <= 30'h0;
               tsh <= {1'b1, tsh[9:1]};
               tn <= tn - 4'h1;
            end
            else
               tc <= tc + 30'h1;
         end
      end

   // Byte receiver; our own bytes come back here as readback
   logic rdone, rferr;
   logic [7:0] rsh;
   logic [3:0] rn;
   logic [29:0] rc;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         rb <= 1'b0;
         rdone <= 1'b0;
         rferr <= 1'b0;
         rsh <= 8'h00;
         rn <= 4'h0;
         rc <= 30'h0;
      end
      else if (run)
      begin
         rdone <= 1'b0;
         if (!rb)
         begin
            if (fall)
            begin
               rb <= 1'b1;
               rc <= bit_len >> 1;
               rn <= 4'h0;
            end
         end
         else if (rc == 30'h0)
         begin
            rc <= bit_len - 30'h1;
            rn <= rn + 4'h1;
            if (rn == 4'h0 && line)
               rb <= 1'b0;
            else if (rn == 4'h9)
            begin
               rb <= 1'b0;
               rdone <= 1'b1;
               rferr <= ~line;
            end
            else if (rn != 4'h0)
               rsh <= {line, rsh[7:1]};
         end
         else
            rc <= rc - 30'h1;
      end

   // Break: at least eleven dominant bits, seen at its rising edge
   logic brk_ev;
   logic [3:0] lb;
   logic [29:0] lc;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         brk_ev <= 1'b0;
         lb <= 4'h0;
         lc <= 30'h0;
      end
      else if (run)
      begin
         brk_ev <= 1'b0;
         if (line)
         begin
            brk_ev <= lb >= 4'hB;
            lb <= 4'h0;
            lc <= 30'h0;
         end
         else if (lc == bit_len - 30'h1)
         begin
            lc <= 30'h0;
            if (lb != 4'hF)
               lb <= lb + 4'h1;
         end
         else
            lc <= lc + 30'h1;
      end

   // Sync field: falls at bits 0,2,4,6,8 give eight bit times
   logic [2:0] fn;
   logic [33:0] meas, t2;
   wire [33:0] t2x4 = {t2[31:0], 2'b00};
   wire [33:0] dev = (t2x4 > meas) ? t2x4 - meas : meas - t2x4;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         fn <= 3'h0;
         meas <= 34'h0;
         t2 <= 34'h0;
         adapt_len <= 30'h0;
         adapt_ok <= 1'b0;
         ev_sy <= 1'b0;
      end
      else if (run)
      begin
         ev_sy <= 1'b0;
         if (!adapt_en)
            adapt_ok <= 1'b0;
         if (st != lin_node_pkg::ST_SYNC)
            fn <= 3'h0;
         else if (fall && fn != 3'h5)
         begin
            fn <= fn + 3'h1;
            meas <= 34'h1;
            if (fn == 3'h1)
               t2 <= meas;
            if (fn != 3'h0)
               meas <= meas + 34'h1;
            if (fn == 3'h4 && adapt_en)
            begin
               adapt_len <= meas[32:3]; // R16
               adapt_ok <= 1'b1;
               ev_sy <= dev > (meas >> 3); // R17
            end
         end
         else
            meas <= meas + 34'h1;
      end

   function automatic logic pbit(input logic [6:0] x);
      pbit = (pmode == lin_node_pkg::PAR_EVEN) ? ~^x : ^x; // R03
   endfunction

   function automatic logic [7:0] cadd(input logic [7:0] a,
      input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      cadd = s[7:0] + {7'h00, s[8]};
   endfunction

   // Frame sequencer
   logic [3:0] len, idx;
   logic dir_tx, nr_hit;
   logic [29:0] lc_b;
   logic [7:0] sum;
   wire par_on = pmode != lin_node_pkg::PAR_NONE;
   wire [7:0] pid_tx = par_on ? {pbit(idb[6:0]), idb[6:0]} : idb;
   wire task_hit = ((rsh ^ task_b) & ~mask) == 8'h00; // R13
   wire id_hit = ((rsh ^ idb) & ~mask) == 8'h00 && mask != 8'hFF; // R11
   wire [7:0] sum_n = cadd(sum, rsh);
   wire [2:0] cur = 3'(big ? len - 4'h1 - idx : idx); // R09
   wire [2:0] nxt = 3'(big ? len - 4'h2 - idx : idx + 4'h1); // R09
   logic [3:0] len_n;
   always_comb
   begin
      len_n = 4'(ctrl[`C_LEN_LO+:3]) + 4'h1; // R05
      if (ctrl[`C_LEN_ID]) // R08
         len_n = rsh[5:4] == 2'b11 ? 4'h8 : rsh[5:4] == 2'b10 ? 4'h4 : 4'h2;
      if (!ctrl[`C_MBUF])
         len_n = 4'h1; // R15
   end

   assign brk_drive = st == lin_node_pkg::ST_BRK;

   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         st <= lin_node_pkg::ST_IDLE;
         tx_go <= 1'b0;
         tx_d <= 8'hFF;
         ev_f <= '0;
         rid <= 8'h00;
         len <= 4'h8;
         idx <= 4'h0;
         dir_tx <= 1'b0;
         sum <= 8'h00;
         lc_b <= 30'h0;
         for (int i = 0; i < 8; i++)
            rxb[i] <= 8'h00;
      end
      else if (run)
      begin
         tx_go <= 1'b0;
         ev_f <= '0;
         if (rdone && rferr && st >= lin_node_pkg::ST_SYNC)
         begin
            ev_f[`S_FRM] <= 1'b1;
            st <= lin_node_pkg::ST_IDLE;
         end
         else if (nr_hit)
            st <= lin_node_pkg::ST_IDLE; // R18
         else
         case (st)
            lin_node_pkg::ST_IDLE:
            begin
               lc_b <= 30'h0;
               idx <= 4'h0;
               if (start_hdr) // R10
                  st <= lin_node_pkg::ST_BRK; // R12
               else if (brk_ev)
                  st <= lin_node_pkg::ST_SYNC;
            end
            lin_node_pkg::ST_BRK, lin_node_pkg::ST_DEL:
               if (lc_b == bit_len - 30'h1)
               begin
                  lc_b <= 30'h0;
                  idx <= idx + 4'h1;
                  if (st == lin_node_pkg::ST_DEL)
                  begin
                     tx_go <= 1'b1;
                     tx_d <= 8'h55;
                     st <= lin_node_pkg::ST_SYNC;
                  end
                  else if (idx == 4'hC)
                     st <= lin_node_pkg::ST_DEL;
               end
               else
                  lc_b <= lc_b + 30'h1;
            lin_node_pkg::ST_SYNC:
               if (rdone)
               begin
                  st <= lin_node_pkg::ST_PID;
                  if (cmdr)
                  begin
                     tx_go <= 1'b1;
                     tx_d <= pid_tx;
                  end
               end
            lin_node_pkg::ST_PID:
               if (rdone)
               begin
                  rid <= rsh;
                  idx <= 4'h0;
                  len <= len_n;
                  dir_tx <= ctrl[`C_TASK] & task_hit;
                  sum <= ctrl[`C_ENH] ? rsh : 8'h00; // R14
                  if (par_on && rsh[7] != pbit(rsh[6:0]))
                  begin
                     ev_f[`S_PAR] <= 1'b1; // R04
                     st <= lin_node_pkg::ST_IDLE;
                  end
                  else if (!ctrl[`C_TASK] && !id_hit)
                     st <= lin_node_pkg::ST_IDLE; // R11
                  else
                  begin
                     st <= lin_node_pkg::ST_DATA;
                     if (ctrl[`C_TASK] & task_hit)
                     begin
                        tx_go <= 1'b1;
                        tx_d <= txb[big ? 3'(len_n - 4'h1) : 3'h0];
                     end
                  end
               end
            lin_node_pkg::ST_DATA:
               if (rdone)
               begin
                  sum <= sum_n; // R14
                  idx <= idx + 4'h1;
                  if (!dir_tx)
                     rxb[cur] <= rsh;
                  if (idx == 4'h0 && rid[5:0] == `SLEEP_ID && rsh == 8'h00
                     && !ctrl[`C_LOWPWR] && !cmdr)
                     ev_f[`S_WAKEUP] <= 1'b1; // R22
                  if (idx == len - 4'h1)
                  begin
                     st <= lin_node_pkg::ST_CSUM;
                     tx_go <= dir_tx;
                     tx_d <= ~sum_n;
                  end
                  else if (dir_tx)
                  begin
                     tx_go <= 1'b1;
                     tx_d <= txb[nxt];
                  end
               end
            lin_node_pkg::ST_CSUM:
               if (rdone)
               begin
                  st <= lin_node_pkg::ST_IDLE;
                  if (rsh != ~sum)
                     ev_f[`S_CSUM] <= 1'b1;
                  else if (dir_tx)
                     ev_f[`S_TXDONE] <= 1'b1;
                  else
                     ev_f[`S_RXRDY] <= 1'b1;
               end
            default: st <= lin_node_pkg::ST_IDLE;
         endcase
      end

   // Responder watchdogs: missing response and idle bus
   logic [15:0] nb;
   logic [29:0] nc;
   logic [31:0] bi;
   wire resp_wait = ~cmdr & ~dir_tx & (st == lin_node_pkg::ST_DATA |
      st == lin_node_pkg::ST_CSUM);
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         nb <= 16'h0;
         nc <= 30'h0;
         nr_hit <= 1'b0;
         bi <= 32'h0;
         ev_nr <= 1'b0;
         ev_bt <= 1'b0;
      end
      else if (run)
      begin
         nr_hit <= 1'b0;
         ev_nr <= 1'b0;
         ev_bt <= 1'b0;
         if (!resp_wait || nr_hit)
         begin
            nb <= 16'h0;
            nc <= 30'h0;
         end
         else if (nc == bit_len - 30'h1)
         begin
            nc <= 30'h0;
            nb <= nb + 16'h1;
            if (nb == `NORESP_BITS - 16'h1)
            begin
               nr_hit <= 1'b1; // R23
               ev_nr <= 1'b1; // R18
            end
         end
         else
            nc <= nc + 30'h1;
         if (!line || cmdr || st != lin_node_pkg::ST_IDLE)
            bi <= 32'h0;
         else if (bi != BUS_IDLE_CYC)
         begin
            bi <= bi + 32'h1;
            ev_bt <= bi == BUS_IDLE_CYC - 32'h1; // R21
         end
      end

   // Wakeup series: pulse, wait for a header, three tries, long pause
   logic [31:0] wc;
   logic [1:0] wn;
   assign wk_drive = wk == lin_node_pkg::WK_PULSE;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         wk <= lin_node_pkg::WK_OFF;
         wc <= 32'h0;
         wn <= 2'h0;
         ev_w1 <= 1'b0;
         ev_w3 <= 1'b0;
      end
      else if (run)
      begin
         ev_w1 <= 1'b0;
         ev_w3 <= 1'b0;
         wc <= wc + 32'h1;
         case (wk)
            lin_node_pkg::WK_OFF:
            begin
               wc <= 32'h0;
               wn <= 2'h0;
               if (wake_go)
                  wk <= lin_node_pkg::WK_PULSE;
            end
            lin_node_pkg::WK_PULSE:
               if (wc == 32'(`WAKE_PULSE_CYC) - 32'h1)
               begin
                  wc <= 32'h0;
                  wk <= lin_node_pkg::WK_WAIT;
               end
            lin_node_pkg::WK_WAIT:
               if (brk_ev)
                  wk <= lin_node_pkg::WK_OFF;
               else if (wc == WAKE_WAIT_CYC - 32'h1)
               begin
                  wc <= 32'h0;
                  ev_w1 <= 1'b1; // R20
                  wn <= wn + 2'h1;
                  wk <= lin_node_pkg::WK_PULSE;
                  if (wn == 2'h2)
                  begin
                     ev_w3 <= 1'b1; // R19
                     wk <= lin_node_pkg::WK_PAUSE;
                  end
               end
            lin_node_pkg::WK_PAUSE:
               if (brk_ev)
                  wk <= lin_node_pkg::WK_OFF;
               else if (wc == WAKE_SERIES_CYC - 32'h1) // R19
               begin
                  wc <= 32'h0;
                  wn <= 2'h0;
                  wk <= lin_node_pkg::WK_PULSE;
               end
            default: wk <= lin_node_pkg::WK_OFF;
         endcase
      end

   always_comb
   begin
      ev = ev_f;
      ev[`S_SYNC] = ev_sy;
      ev[`S_NORESP] = ev_nr;
      ev[`S_BUSTO] = ev_bt;
      ev[`S_WAKE1] = ev_w1;
      ev[`S_WAKE3] = ev_w3;
      if (ctrl[`C_LOWPWR] & ~cmdr & ~line)
         ev[`S_WAKEUP] = 1'b1; // R22
   end
endmodule

// ==== rtl/lin_node_regs.svh ====
// Offsets, field positions, reset values and timing counts of the LIN node
// How it works
// R01 - Loopback: tx feeds rx, pin high
// R02 - Debug halt freezes; free-run finishes first
// R03 - Parity none, odd or even
// R04 - Identifier parity error only with parity
// R05 - Response length one to eight bytes
// R06 - Prescaler 24 bits, fraction 4 bits
// R07 - Bit time 16*(P+1+M/16) module clocks
// R08 - Optional length from identifier bits
// R09 - Little or big endian byte order
// R10 - Commander or responder role select
// R11 - Masked identifier or task-byte filtering
// R12 - Identifier write starts commander header
// R13 - Task byte match picks direction
// R14 - Classic or enhanced checksum
// R15 - Multibuffer or single byte register
// R16 - Responder adapts bit rate on sync
// R17 - Inconsistent sync field flag
// R18 - No-response timeout flag
// R19 - Three wakeups unanswered flag, 1.5 s
// R20 - One wakeup unanswered flag, 150 ms
// R21 - Four seconds bus idle flag
// R22 - Wakeup flag on low level or sleep
// R23 - No-response timeout counted in bits
`ifndef LIN_NODE_REGS_SVH
`define LIN_NODE_REGS_SVH

`define CLK_MHZ 125
`define OFF_CTRL 8'h00
`define OFF_PRESC 8'h04
`define OFF_FRAC 8'h08
`define OFF_ID 8'h0C
`define OFF_INTEN 8'h10
`define OFF_STAT 8'h14
`define OFF_DATA_LO 8'h18
`define OFF_DATA_HI 8'h1C

`define C_LOOP 0
`define C_CMDR 1
`define C_PAR_LO 2
`define C_FREE 4
`define C_LEN_ID 5
`define C_BIG 6
`define C_ENH 7
`define C_MBUF 8
`define C_ADAPT 9
`define C_TASK 10
`define C_LEN_LO 11
`define C_LOWPWR 14
`define C_WAKE 15
`define CTRL_RST 32'h00003D00
`define PRESC_RST 24'h00000F
`define FRAC_RST 4'h4
`define ID_RST 32'h0000303A

`define S_PAR 0
`define S_FRM 1
`define S_CSUM 2
`define S_SYNC 3
`define S_NORESP 4
`define S_WAKE3 5
`define S_WAKE1 6
`define S_BUSTO 7
`define S_WAKEUP 8
`define S_RXRDY 9
`define S_TXDONE 10
`define NFLAG 11

`define SLEEP_ID 6'h3C
`define NORESP_BITS 16'd120
`define WAKE_PULSE_US 250
`define WAKE_PULSE_CYC (`WAKE_PULSE_US * `CLK_MHZ)
`define WAKE_WAIT_MS 150
`define WAKE_SERIES_MS 1500
`define BUS_IDLE_MS 4000
`define WAKE_WAIT_CYC (`WAKE_WAIT_MS * `CLK_MHZ * 1000)
`define WAKE_SERIES_CYC (`WAKE_SERIES_MS * `CLK_MHZ * 1000)
`define BUS_IDLE_CYC (`BUS_IDLE_MS * `CLK_MHZ * 1000)

`endif

// ==== rtl/lin_node_pkg.sv ====
// Types shared by the LIN node
package lin_node_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_BRK, ST_DEL, ST_SYNC, ST_PID,
      ST_DATA, ST_CSUM} frame_t;
   typedef enum logic [1:0] {WK_OFF, WK_PULSE, WK_WAIT, WK_PAUSE} wake_t;
   typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_t;
endpackage

// ==== tb/lin_node_sva.sv ====
// Checker of bus handshake, pin and flag behaviour of the LIN node
`timescale 1ns/10ps
`include "lin_node_regs.svh"
module lin_node_sva (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic wb_we_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic debug_halt_in,
   input wire logic bus_transmit_out,
   input wire logic irq_out
);
   logic [7:0] ctrl;
   logic [10:0] inten;
   logic wr_hit;
   assign wr_hit = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // Shadow copy, lands on the same edge as the slave's own write
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ctrl <= 8'h00;
         inten <= 11'h000;
      end
      else if (wr_hit)
      begin
         if (wb_adr_in == `OFF_CTRL && wb_sel_in[0])
            ctrl <= wb_dat_in[7:0];
         if (wb_adr_in == `OFF_INTEN && wb_sel_in[0])
            inten[7:0] <= wb_dat_in[7:0];
         if (wb_adr_in == `OFF_INTEN && wb_sel_in[1])
            inten[10:8] <= wb_dat_in[10:8];
      end
   end
   sequence s_hdr_wr;
      wr_hit && wb_adr_in == `OFF_ID && wb_sel_in[0];
   endsequence
   sequence s_break;
      !bus_transmit_out [*8];
   endsequence
   AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   AST_ACK_ANSWER: assert property
      (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("request not answered next cycle");
   AST_ACK_CAUSE: assert property
      (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   AST_UNMAPPED_ZERO: assert property
      (wb_ack_out && !wb_we_in && wb_adr_in[7:5] != 3'h0 |-> !wb_dat_out)
      else $error("unmapped read not zero");
   AST_LOOP_PIN_HIGH: assert property
      (ctrl[0] && $past(ctrl[0]) |-> bus_transmit_out)
      else $error("pin not high in loopback");
   AST_HALT_FREEZE: assert property
      (debug_halt_in [*3] ##0 !ctrl[4] |-> $stable(bus_transmit_out))
      else $error("pin moved while halted");
   AST_IRQ_MASKED: assert property
      (inten == 11'h000 |-> !irq_out)
      else $error("interrupt with all flags masked");
   AST_HEADER_BREAK: assert property
      (s_hdr_wr ##0 (ctrl[1] && !ctrl[0] && !debug_halt_in)
       |-> ##[1:4] s_break)
      else $error("no break after identifier write");
endmodule
bind lin_bus_node_controller lin_node_sva i_sva (.clk_in, .rstn_in,
   .wb_adr_in, .wb_dat_in, .wb_sel_in, .wb_we_in, .wb_cyc_in, .wb_stb_in,
   .wb_dat_out, .wb_ack_out, .debug_halt_in, .bus_transmit_out, .irq_out);

// ==== tb/lin_peer.sv ====
// Listening LIN node: measures the break and decodes four frame bytes
`timescale 1ns/10ps
module lin_peer #(parameter int BIT = 32) (
   input wire logic clk_in,
   input wire logic line_in,
   output logic rx_out,
   output int brk_out,
   output logic [31:0] cap_out,
   output int nfrm_out
);
   logic [7:0] b;
   // Stays recessive, so the pulled-up wire shows the sender's level
   assign rx_out = line_in;
   initial
   begin
      brk_out = 0;
      cap_out = 32'h00000000;
      nfrm_out = 0;
      forever
      begin
         @(negedge line_in);
         brk_out = 0;
         while (line_in !== 1'b1)
         begin
            @(posedge clk_in);
            brk_out++;
         end
         repeat (4)
         begin
            @(negedge line_in);
            repeat (BIT * 3 / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++)
            begin
               b[i] = line_in;
               repeat (BIT) @(posedge clk_in);
            end
            cap_out = {cap_out[23:0], b};
         end
         nfrm_out++;
      end
   end
endmodule

// ==== tb/lin_bus_node_controller_test.sv ====
// Register and frame tests of the LIN node
`timescale 1ns/10ps
`include "lin_node_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module lin_bus_node_controller_test;
   localparam int BIT = 2 * (16 * (0 + 1) + 0);
   logic clk_in, rstn_in, cyc, stb, we, halt, ack, tx, rx, irq;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, d, cap;
   logic [3:0] sel;
   int error_cnt, tests_run, nfrm, brk;
   logic [7:0] ra [5] = '{`OFF_CTRL, `OFF_PRESC, `OFF_FRAC, `OFF_ID, 8'h40};
   logic [31:0] rv [5] = '{`CTRL_RST, 32'h0000000F, 32'h00000004, `ID_RST,
      32'h00000000};
   logic [31:0] fc [2] = '{32'h00000506, 32'h0000058A};
   logic [31:0] fx [2] = '{32'h5590A55A, 32'h5510A54A};
   lin_bus_node_controller #(.WAKE_WAIT_CYC(32'h000003E8),
      .WAKE_SERIES_CYC(32'h00000BB8), .BUS_IDLE_CYC(32'h000007D0)) i_dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_dat_out(rdat), .wb_ack_out(ack), .debug_halt_in(halt),
      .bus_receive_in(rx), .bus_transmit_out(tx), .irq_out(irq));
   lin_peer #(.BIT(BIT)) i_peer (.clk_in(clk_in), .line_in(tx),
      .rx_out(rx), .brk_out(brk), .cap_out(cap), .nfrm_out(nfrm));
   task final_report;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s);
      @(posedge clk_in);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, v, s};
      do @(posedge clk_in); while (ack !== 1'b1);
      d = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial
   begin
      #400000;
      error_cnt++;
      final_report;
   end
   initial
   begin
      {rstn_in, cyc, stb, we, halt, adr, wdat, sel} = '0;
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         wb(0, ra[i], 0, 4'hF);
         `CHK(d, rv[i])
      end
      wb(1, `OFF_PRESC, 32'hFFFFFFFF, 4'hF);
      wb(0, `OFF_PRESC, 0, 4'hF);
      `CHK(d, 32'h00FFFFFF)
      wb(1, `OFF_PRESC, 0, 4'hF);
      wb(1, `OFF_FRAC, 0, 4'hF);
      wb(1, `OFF_INTEN, 32'h00000480, 4'h3);
      repeat (2100) @(posedge clk_in);
      wb(0, `OFF_STAT, 0, 4'hF);
      `CHK({d[7], irq}, 2'b11)
      for (int i = 0; i < 2; i++)
      begin
         wb(1, `OFF_STAT, 32'h000007FF, 4'h3);
         wb(1, `OFF_DATA_LO, 32'h000000A5, 4'h1);
         wb(1, `OFF_CTRL, fc[i], 4'h3);
         wb(1, `OFF_ID, 32'h00801010, 4'hF);
         while (nfrm != i + 1) @(posedge clk_in);
         `CHK(cap, fx[i])
         `CHK(brk / BIT, 13)
         repeat (2 * BIT) @(posedge clk_in);
         `CHK(irq, 1'b1)
      end
      wb(1, `OFF_STAT, 32'h000007FF, 4'h3);
      @(posedge clk_in);
      `CHK(irq, 1'b0)
      wb(1, `OFF_CTRL, 32'h00000502, 4'h3);
      wb(1, `OFF_ID, 32'h00801010, 4'hF);
      halt <= 1'b1;
      repeat (40) @(posedge clk_in);
      halt <= 1'b0;
      while (nfrm != 3) @(posedge clk_in);
      `CHK({brk, cap}, {int'(13 * BIT + 41), 32'h5510A55A})
      repeat (BIT) @(posedge clk_in);
      wb(1, `OFF_CTRL, 32'h00000503, 4'h3);
      wb(1, `OFF_ID, 32'h00801010, 4'hF);
      repeat (600) @(posedge clk_in);
      `CHK({tx, nfrm[1:0]}, 3'b111)
      final_report;
   end
endmodule
